// ---- iiw_host_model.sv ----
// Host processor model driving the APB register port
`timescale 1ns/10ps
`default_nettype none
`include "iiw_params.svh"
module iiw_host_model (
    input wire logic clk,
    output logic [7:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Software copy of the sync source overview, used to spot slips
    logic [31:0] sync_copy = 32'h0;
    initial begin
        {paddr, psel, penable, pwrite, pwdata} = '0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err, output logic ok);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // Wait states are legal; the bound stops a stuck slave from hanging the run
        while (pready !== 1'b1 && n < 16) begin
            @(posedge clk);
            n++;
        end
        ok = (n < 16);
        q = prdata;
        err = pslverr;
        if (!w && a == `IIW_A_SYNC_OVIEW) sync_copy = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : iiw_host_model
`default_nettype wire

// ---- iiw_params.svh ----
// Constants for the ISDN interrupt collector and watchdog
`ifndef IIW_PARAMS_SVH
`define IIW_PARAMS_SVH
`define IIW_CLK_MHZ 40
`define IIW_FRAME_US 125
`define IIW_TIMER_UNIT_US 250
`define IIW_WD_TICK_US 2000
`define IIW_WD_TICK_CYC (`IIW_WD_TICK_US * `IIW_CLK_MHZ)
`define IIW_TIMER_FRAMES (`IIW_TIMER_UNIT_US / `IIW_FRAME_US)
`define IIW_A_IRQ_CTRL 8'h00
`define IIW_A_OVERVIEW 8'h04
`define IIW_A_LINE_MASK 8'h08
`define IIW_A_LINE_STAT 8'h0c
`define IIW_A_MISC_MASK 8'h10
`define IIW_A_MISC_STAT 8'h14
`define IIW_A_FIFO_STAT0 8'h18
`define IIW_A_FIFO_MASK0 8'h28
`define IIW_A_TI_WD 8'h38
`define IIW_A_WD_MODE 8'h3c
`define IIW_A_WAKE_MODE 8'h40
`define IIW_A_SYNC_OVIEW 8'h44
`define IIW_B_GLOB_EN 0
`define IIW_B_FIFO_EN 1
`define IIW_B_OV_MISC 4
`define IIW_B_OV_LINE 5
`define IIW_B_WD_RESTART 0
`define IIW_B_WD_AUTO 1
`define IIW_B_WAKE_EN 0
`define IIW_F_TI_EXP_LSB 0
`define IIW_F_WD_EXP_LSB 4
`define IIW_RST_TI_WD 8'h00
`endif

// ---- iiw_pkg.sv ----
// Types for the ISDN interrupt collector and watchdog
package iiw_pkg;
    typedef enum logic [2:0] {
        MISC_SLIP, MISC_TIMER, MISC_PROC, MISC_CI, MISC_WAKE, MISC_MON_TX, MISC_MON_RX
    } iiw_misc_src_t;
    typedef logic [6:0] iiw_misc_t;
    typedef logic [3:0] iiw_exp_t;
endpackage : iiw_pkg

// ---- iiw_watchdog.sv ----
// Watchdog counter with 2 ms prescaler and active-low output
`timescale 1ns/10ps
`default_nettype none
`include "iiw_params.svh"
module iiw_watchdog import iiw_pkg::*; #(
    parameter int TICK_CYCLES = `IIW_WD_TICK_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    iiw_wd_if.wd wd,
    output logic watchdog_out_n
);
    logic [19:0] prescale;
    logic tick;
    logic [15:0] wd_cnt;
    logic [15:0] limit;

    assign tick = (prescale == 20'(TICK_CYCLES - 1));
    assign limit = 16'((32'h1 << wd.exponent) - 1);
    assign wd.expired = ~watchdog_out_n;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prescale <= 20'h0;
        end else if (wd.restart || tick) begin
            prescale <= 20'h0;
        end else begin
            prescale <= prescale + 20'h1;
        end
    end

    // Counter freezes once expired so the pin stays low until a restart
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wd_cnt <= 16'h0;
            watchdog_out_n <= 1'b1;
        end else if (wd.restart) begin
            wd_cnt <= 16'h0;
            watchdog_out_n <= 1'b1;
        end else if (tick && watchdog_out_n) begin
            if (wd_cnt == limit) begin
                watchdog_out_n <= 1'b0;
            end else begin
                wd_cnt <= wd_cnt + 16'h1;
            end
        end
    end

    wd_expire_a: assert property (@(posedge clk) disable iff (!resetn)
        (tick && watchdog_out_n && wd_cnt == limit && !wd.restart) |=> !watchdog_out_n)
        else $error("watchdog did not expire at limit");
    wd_restart_a: assert property (@(posedge clk) disable iff (!resetn)
        wd.restart |=> (watchdog_out_n && wd_cnt == 16'h0 && prescale == 20'h0))
        else $error("watchdog restart did not clear");
    wd_expire_c: cover property (@(posedge clk) disable iff (!resetn) $fell(watchdog_out_n));
endmodule : iiw_watchdog
`default_nettype wire

// ---- iiw_wd_if.sv ----
// Link between register logic and the watchdog counter
`timescale 1ns/10ps
`default_nettype none
interface iiw_wd_if;
    import iiw_pkg::*;
    logic restart;
    iiw_exp_t exponent;
    logic expired;
    modport ctrl (output restart, output exponent, input expired);
    modport wd (input restart, input exponent, output expired);
endinterface : iiw_wd_if
`default_nettype wire

// ---- isdn_irq_and_watchdog.sv ----
// Interrupt collector and watchdog for the ISDN line and FIFO controller
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "iiw_params.svh"
module isdn_irq_and_watchdog import iiw_pkg::*; #(
    parameter int N_LINES = 2,
    parameter int N_FIFOS = 32,
    parameter int CI_BITS = 4,
    parameter int WD_TICK_CYCLES = `IIW_WD_TICK_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [N_LINES-1:0] line_state_change,
    input wire logic [N_LINES-1:0] sync_source_select,
    input wire logic [N_FIFOS-1:0] transparent_select,
    input wire logic [N_FIFOS-1:0] mixed_irq_select,
    input wire logic [N_FIFOS-1:0] fifo_end_of_frame,
    input wire logic [N_FIFOS-1:0] fifo_underrun,
    input wire logic [N_FIFOS-1:0] fifo_condition,
    input wire logic frame_pulse,
    input wire logic proc_done,
    input wire logic [CI_BITS-1:0] ci_indication,
    input wire logic wakeup_pin,
    input wire logic monitor_tx_ready,
    input wire logic monitor_rx_stored,
    output logic irq_n,
    output logic watchdog_out_n
);
    iiw_wd_if wd_link ();

    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic mapped;
    logic [31:0] next_rdata;
    logic global_irq_enable;
    logic fifo_irq_enable;
    logic [N_LINES-1:0] line_irq_mask;
    logic [N_LINES-1:0] line_irq_status;
    iiw_misc_t misc_mask;
    iiw_misc_t misc_status;
    iiw_misc_t misc_set;
    logic [N_FIFOS-1:0] fifo_mask;
    logic [N_FIFOS-1:0] fifo_status;
    logic [N_FIFOS-1:0] fifo_set;
    logic [3:0] fifo_block_summary;
    logic [3:0] fifo_block_rd;
    iiw_exp_t timer_exponent;
    iiw_exp_t watchdog_exponent;
    logic watchdog_restart;
    logic watchdog_auto_restart;
    logic wakeup_pin_enable;
    logic [5:0] irq_overview;
    logic [2:0] frame_sync;
    logic [1:0] wake_sync;
    logic frame_tick;
    logic [16:0] timer_cnt;
    logic timer_evt;
    logic [N_LINES-1:0] sync_prev;
    logic [CI_BITS-1:0] ci_prev;
    logic any_pending;

    // APB slave: zero wait states, so pready is a constant handshake
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign rd = access && !pwrite;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    always_comb begin
        mapped = 1'b1;
        next_rdata = 32'h0;
        unique case (paddr)
            `IIW_A_IRQ_CTRL: begin
                next_rdata[`IIW_B_GLOB_EN] = global_irq_enable;
                next_rdata[`IIW_B_FIFO_EN] = fifo_irq_enable;
            end
            `IIW_A_OVERVIEW: next_rdata[5:0] = irq_overview;
            `IIW_A_LINE_MASK: next_rdata[N_LINES-1:0] = line_irq_mask;
            `IIW_A_LINE_STAT: next_rdata[N_LINES-1:0] = line_irq_status;
            `IIW_A_MISC_MASK: next_rdata[6:0] = misc_mask;
            `IIW_A_MISC_STAT: next_rdata[6:0] = misc_status;
            `IIW_A_FIFO_STAT0: next_rdata[7:0] = fifo_status[7:0];
            `IIW_A_FIFO_STAT0 + 8'h04: next_rdata[7:0] = fifo_status[15:8];
            `IIW_A_FIFO_STAT0 + 8'h08: next_rdata[7:0] = fifo_status[23:16];
            `IIW_A_FIFO_STAT0 + 8'h0c: next_rdata[7:0] = fifo_status[31:24];
            `IIW_A_FIFO_MASK0: next_rdata[7:0] = fifo_mask[7:0];
            `IIW_A_FIFO_MASK0 + 8'h04: next_rdata[7:0] = fifo_mask[15:8];
            `IIW_A_FIFO_MASK0 + 8'h08: next_rdata[7:0] = fifo_mask[23:16];
            `IIW_A_FIFO_MASK0 + 8'h0c: next_rdata[7:0] = fifo_mask[31:24];
            `IIW_A_TI_WD: begin
                next_rdata[`IIW_F_TI_EXP_LSB +: 4] = timer_exponent;
                next_rdata[`IIW_F_WD_EXP_LSB +: 4] = watchdog_exponent;
            end
            `IIW_A_WD_MODE: begin
                next_rdata[`IIW_B_WD_RESTART] = watchdog_restart;
                next_rdata[`IIW_B_WD_AUTO] = watchdog_auto_restart;
            end
            `IIW_A_WAKE_MODE: next_rdata[`IIW_B_WAKE_EN] = wakeup_pin_enable;
            `IIW_A_SYNC_OVIEW: next_rdata[N_LINES-1:0] = sync_source_select;
            default: mapped = 1'b0;
        endcase
    end

    // Read data is captured in the setup cycle; the same value is the clear
    // mask in the access cycle, so nothing set in between is dropped
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h0;
        end else if (setup && !pwrite) begin
            prdata <= next_rdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            global_irq_enable <= 1'b0;
            fifo_irq_enable <= 1'b0;
            line_irq_mask <= '0;
            misc_mask <= '0;
            timer_exponent <= 4'(`IIW_RST_TI_WD >> `IIW_F_TI_EXP_LSB);
            watchdog_exponent <= 4'(`IIW_RST_TI_WD >> `IIW_F_WD_EXP_LSB);
            watchdog_auto_restart <= 1'b0;
            wakeup_pin_enable <= 1'b0;
        end else if (wr) begin
            unique case (paddr)
                `IIW_A_IRQ_CTRL: begin
                    global_irq_enable <= pwdata[`IIW_B_GLOB_EN];
                    fifo_irq_enable <= pwdata[`IIW_B_FIFO_EN];
                end
                `IIW_A_LINE_MASK: line_irq_mask <= pwdata[N_LINES-1:0];
                `IIW_A_MISC_MASK: misc_mask <= pwdata[6:0];
                `IIW_A_TI_WD: begin
                    timer_exponent <= pwdata[`IIW_F_TI_EXP_LSB +: 4];
                    watchdog_exponent <= pwdata[`IIW_F_WD_EXP_LSB +: 4];
                end
                `IIW_A_WD_MODE: watchdog_auto_restart <= pwdata[`IIW_B_WD_AUTO];
                `IIW_A_WAKE_MODE: wakeup_pin_enable <= pwdata[`IIW_B_WAKE_EN];
                default: ;
            endcase
        end
    end

    // Restart bit is only ever seen high for one cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            watchdog_restart <= 1'b0;
        end else begin
            watchdog_restart <= wr && paddr == `IIW_A_WD_MODE && pwdata[`IIW_B_WD_RESTART];
        end
    end

    assign wd_link.restart = watchdog_restart || (watchdog_auto_restart && access);
    assign wd_link.exponent = watchdog_exponent;

    iiw_watchdog #(
        .TICK_CYCLES(WD_TICK_CYCLES)
    ) u_watchdog (
        .clk(clk),
        .resetn(resetn),
        .wd(wd_link.wd),
        .watchdog_out_n(watchdog_out_n)
    );

    // Pins from outside the clock domain
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            frame_sync <= 3'h0;
            wake_sync <= 2'h0;
        end else begin
            frame_sync <= {frame_sync[1:0], frame_pulse};
            wake_sync <= {wake_sync[0], wakeup_pin};
        end
    end

    assign frame_tick = frame_sync[1] && !frame_sync[2];

    // 2^n x 250 us is 2^(n+1) frame pulses
    assign timer_evt = frame_tick && (timer_cnt == 17'(((`IIW_TIMER_FRAMES) << timer_exponent) - 1));

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            timer_cnt <= 17'h0;
        end else if (timer_evt) begin
            timer_cnt <= 17'h0;
        end else if (frame_tick) begin
            timer_cnt <= timer_cnt + 17'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync_prev <= '0;
            ci_prev <= '0;
        end else begin
            sync_prev <= sync_source_select;
            ci_prev <= ci_indication;
        end
    end

    always_comb begin
        misc_set = '0;
        misc_set[MISC_SLIP] = |(sync_source_select ^ sync_prev);
        misc_set[MISC_TIMER] = timer_evt;
        misc_set[MISC_PROC] = proc_done;
        misc_set[MISC_CI] = ci_indication != ci_prev;
        misc_set[MISC_WAKE] = wakeup_pin_enable && wake_sync[1];
        misc_set[MISC_MON_TX] = monitor_tx_ready;
        misc_set[MISC_MON_RX] = monitor_rx_stored;
    end

    genvar gi;
    generate
        for (gi = 0; gi < N_FIFOS; gi++) begin : g_fifo
            always_comb begin
                if (!fifo_irq_enable) begin
                    fifo_set[gi] = 1'b0;
                end else if (transparent_select[gi]) begin
                    fifo_set[gi] = fifo_condition[gi];
                end else begin
                    fifo_set[gi] = fifo_end_of_frame[gi] || fifo_underrun[gi]
                        || (mixed_irq_select[gi] && fifo_condition[gi]);
                end
            end
        end
        for (gi = 0; gi < 4; gi++) begin : g_block
            assign fifo_block_rd[gi] = rd && paddr == 8'(`IIW_A_FIFO_STAT0 + 4 * gi);
            assign fifo_block_summary[gi] = |(fifo_status[8*gi +: 8] & fifo_mask[8*gi +: 8]);
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    fifo_status[8*gi +: 8] <= 8'h00;
                    fifo_mask[8*gi +: 8] <= 8'h00;
                end else begin
                    fifo_status[8*gi +: 8] <= (fifo_status[8*gi +: 8]
                        & ~(fifo_block_rd[gi] ? prdata[7:0] : 8'h00)) | fifo_set[8*gi +: 8];
                    if (wr && paddr == 8'(`IIW_A_FIFO_MASK0 + 4 * gi)) begin
                        fifo_mask[8*gi +: 8] <= pwdata[7:0];
                    end
                end
            end
        end
    endgenerate

    // Set wins over the read clear, so a coincident event is kept
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            line_irq_status <= '0;
        end else begin
            line_irq_status <= (line_irq_status
                & ~((rd && paddr == `IIW_A_LINE_STAT) ? prdata[N_LINES-1:0] : '0))
                | line_state_change;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            misc_status <= '0;
        end else begin
            misc_status <= (misc_status & ~((rd && paddr == `IIW_A_MISC_STAT) ? prdata[6:0] : 7'h00))
                | misc_set;
        end
    end

    always_comb begin
        irq_overview = 6'h00;
        irq_overview[3:0] = fifo_block_summary;
        irq_overview[`IIW_B_OV_MISC] = |(misc_status & misc_mask);
        irq_overview[`IIW_B_OV_LINE] = |(line_irq_status & line_irq_mask);
    end

    assign any_pending = global_irq_enable && (|irq_overview);

    // Registered pin avoids glitches from the overview gating
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= !any_pending;
        end
    end

    irq_follow_a: assert property (@(posedge clk) disable iff (!resetn)
        ((|(misc_status & misc_mask)) && global_irq_enable) |=> !irq_n)
        else $error("interrupt pin not asserted for enabled misc status");
    glob_off_a: assert property (@(posedge clk) disable iff (!resetn)
        !global_irq_enable |=> irq_n)
        else $error("interrupt pin active while globally disabled");
    line_record_a: assert property (@(posedge clk) disable iff (!resetn)
        (|line_state_change) |=> ((line_irq_status & $past(line_state_change)) == $past(line_state_change)))
        else $error("line state change not recorded");
    fifo_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        !fifo_irq_enable |=> ((fifo_status & ~$past(fifo_status)) == '0))
        else $error("fifo status set while fifo interrupts disabled");
    timer_status_a: assert property (@(posedge clk) disable iff (!resetn)
        timer_evt |=> misc_status[MISC_TIMER])
        else $error("timer event not recorded");
    read_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        (rd && paddr == `IIW_A_MISC_STAT)
        |=> ((misc_status & $past(prdata[6:0]) & ~$past(misc_set)) == 7'h00))
        else $error("misc status not cleared by read");
    restart_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
        watchdog_restart |=> !watchdog_restart)
        else $error("watchdog restart bit did not self clear");
    wake_latch_a: assert property (@(posedge clk) disable iff (!resetn)
        (wakeup_pin_enable && wake_sync[1]) |=> misc_status[MISC_WAKE])
        else $error("wakeup level not latched");
    slip_set_a: assert property (@(posedge clk) disable iff (!resetn)
        $changed(sync_source_select) |=> misc_status[MISC_SLIP])
        else $error("sync source change did not set slip status");

    irq_raise_c: cover property (@(posedge clk) disable iff (!resetn) $fell(irq_n));
    fifo_event_c: cover property (@(posedge clk) disable iff (!resetn) |fifo_set);
    read_race_c: cover property (@(posedge clk) disable iff (!resetn)
        rd && paddr == `IIW_A_MISC_STAT && |misc_set);
    wd_expired_c: cover property (@(posedge clk) disable iff (!resetn) $rose(wd_link.expired));
endmodule : isdn_irq_and_watchdog
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the interrupt collector and watchdog
`timescale 1ns/10ps
`default_nettype none
`include "iiw_params.svh"
module testbench import iiw_pkg::*;;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] paddr;
    logic psel, penable, pwrite, pready, pslverr, irq_n, watchdog_out_n;
    logic [31:0] pwdata, prdata;
    logic [1:0] line_state_change = '0, sync_source_select = '0;
    logic [31:0] transparent_select = 32'h0000_0018, mixed_irq_select = 32'h0002_0000;
    logic [31:0] fifo_end_of_frame = '0, fifo_underrun = '0, fifo_condition = '0;
    logic frame_pulse = 1'b0, proc_done = 1'b0, wakeup_pin = 1'b0;
    logic monitor_tx_ready = 1'b0, monitor_rx_stored = 1'b0;
    logic [3:0] ci_indication = 4'h0;
    logic [7:0] fifo_exp [4] = '{8'h08, 8'h02, 8'h02, 8'h02};
    int bad_count = 0;
    int cmp_count = 0;
    always #12.5 clk = ~clk;
    isdn_irq_and_watchdog #(.WD_TICK_CYCLES(10)) isdn_irq_and_watchdog_inst (
        .clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .line_state_change, .sync_source_select, .transparent_select, .mixed_irq_select,
        .fifo_end_of_frame, .fifo_underrun, .fifo_condition, .frame_pulse, .proc_done,
        .ci_indication, .wakeup_pin, .monitor_tx_ready, .monitor_rx_stored, .irq_n, .watchdog_out_n);
    iiw_host_model iiw_host_model_inst (.clk, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr);
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    // Sample one step after the edge so the design's own updates have landed
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        logic [31:0] q;
        logic err, ok;
        iiw_host_model_inst.xfer(w, a, d, q, err, ok);
        if (!ok) begin
            bad_count++;
            complete_run();
        end
        if (!w) chk("prdata", e, q);
        chk("pslverr", {31'h0, a == 8'hfc}, {31'h0, err});
    endtask : xf
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xf(1'b1, a, d, 32'h0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xf(1'b0, a, 32'h0, e);
    endtask : rd
    task automatic misc_ev(input int k);
        @(posedge clk);
        case (k)
            // Line 1 stands for an unused interface and keeps its sync source steady
            0: sync_source_select[0] <= ~sync_source_select[0];
            2: proc_done <= 1'b1;
            3: ci_indication <= ci_indication + 4'h1;
            4: wakeup_pin <= 1'b1;
            5: monitor_tx_ready <= 1'b1;
            default: monitor_rx_stored <= 1'b1;
        endcase
        @(posedge clk);
        {proc_done, wakeup_pin, monitor_tx_ready, monitor_rx_stored} <= '0;
        tick(5);
    endtask : misc_ev
    task automatic fp(input logic [31:0] c, input logic [31:0] f, input logic [31:0] u);
        @(posedge clk);
        {fifo_condition, fifo_end_of_frame, fifo_underrun} <= {c, f, u};
        @(posedge clk);
        {fifo_condition, fifo_end_of_frame, fifo_underrun} <= '0;
        tick(3);
    endtask : fp
    initial begin
        tick(5);
        chk("irq_n", 1, irq_n);
        @(posedge clk);
        resetn <= 1'b1;
        rd(8'hfc, 32'h0);
        wr(`IIW_A_WAKE_MODE, 32'h1);
        for (int k = 0; k < 7; k++) begin
            if (k != 1) begin
                misc_ev(k);
                rd(`IIW_A_MISC_STAT, 32'h1 << k);
                rd(`IIW_A_MISC_STAT, 32'h0);
            end
        end
        chk("irq_n", 1, irq_n);
        wr(`IIW_A_MISC_MASK, 32'h4);
        misc_ev(2);
        chk("irq_n", 1, irq_n);
        wr(`IIW_A_IRQ_CTRL, 32'h1);
        tick(2);
        chk("irq_n", 0, irq_n);
        rd(`IIW_A_OVERVIEW, 32'h10);
        rd(`IIW_A_MISC_STAT, 32'h4);
        tick(2);
        chk("irq_n", 1, irq_n);
        wr(`IIW_A_LINE_MASK, 32'h2);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            line_state_change <= 2'(1 << i);
            @(posedge clk);
            line_state_change <= 2'b00;
            tick(3);
            chk("irq_n", 32'(i == 0), irq_n);
        end
        rd(`IIW_A_OVERVIEW, 32'h20);
        rd(`IIW_A_LINE_STAT, 32'h3);
        // FIFO events with the FIFO enable still off leave nothing behind
        fp(32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff);
        for (int b = 0; b < 4; b++) rd(`IIW_A_FIFO_STAT0 + 8'(4 * b), 32'h0);
        wr(`IIW_A_IRQ_CTRL, 32'h3);
        wr(`IIW_A_FIFO_MASK0 + 8'h08, 32'h2);
        // FIFO 4 and FIFO 10 see events outside their mode and must stay clear
        fp(32'h0002_0408, 32'h0000_0210, 32'h0200_0000);
        rd(`IIW_A_OVERVIEW, 32'h04);
        chk("irq_n", 0, irq_n);
        for (int b = 0; b < 4; b++) rd(`IIW_A_FIFO_STAT0 + 8'(4 * b), 32'(fifo_exp[b]));
        wr(`IIW_A_TI_WD, 32'h11);
        for (int i = 1; i < 5; i++) begin
            @(posedge clk);
            frame_pulse <= 1'b1;
            repeat (2) @(posedge clk);
            frame_pulse <= 1'b0;
            tick(6);
            rd(`IIW_A_MISC_STAT, (i == 4) ? 32'h2 : 32'h0);
        end
        chk("irq_n", 1, irq_n);
        wr(`IIW_A_WD_MODE, 32'h1);
        tick(1);
        chk("watchdog_out_n", 1, watchdog_out_n);
        tick(14);
        chk("watchdog_out_n", 1, watchdog_out_n);
        tick(8);
        chk("watchdog_out_n", 0, watchdog_out_n);
        rd(`IIW_A_WD_MODE, 32'h0);
        wr(`IIW_A_WD_MODE, 32'h2);
        repeat (4) begin
            tick(8);
            rd(`IIW_A_SYNC_OVIEW, {30'h0, sync_source_select});
        end
        chk("watchdog_out_n", 1, watchdog_out_n);
        chk("sync_copy", 32'h1, iiw_host_model_inst.sync_copy);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
